// file: lvt_video_timing.sv
`timescale 1ns/1ps
`default_nettype none
module lvt_video_timing (
  input  wire logic        clk_i,          // 20 MHz system clock
  input  wire logic        rst_i,          // Synchronous, active high
  input  wire logic        wb_cyc_i,       // Wishbone cycle
  input  wire logic        wb_stb_i,       // Wishbone strobe
  input  wire logic        wb_we_i,        // Wishbone write
  input  wire logic [7:0]  wb_adr_i,       // Byte address
  input  wire logic [3:0]  wb_sel_i,       // Byte lanes
  input  wire logic [31:0] wb_dat_i,       // Write data
  output logic      [31:0] wb_dat_o,       // Read data
  output logic             wb_ack_o,       // Acknowledge
  input  wire logic        pclk_i,         // Pixel clock from outside
  input  wire logic        hs_in_i,        // Received line sync
  input  wire logic        vs_in_i,        // Received frame sync
  input  wire logic        chan_single_i,  // 1 single, 0 dual channel
  input  wire logic        in_valid_i,     // Pixel word offered
  input  wire lvt_pkg::lvt_pix_t in_data_i, // Pixel word
  output logic             in_ready_o,     // Buffer can take a word
  output logic             hsync_o,        // Panel hsync
  output logic             vsync_o,        // Panel vsync
  output logic             de_o,           // Panel data enable
  output lvt_pkg::lvt_pix_t ch_a_data_o,   // Channel A pixel
  output lvt_pkg::lvt_pix_t ch_b_data_o,   // Channel B pixel
  output logic             ch_b_en_o       // Channel B in use
);

  // ========================================================
  // Input synchronisers: pixel clock and the two syncs
  // ========================================================
  logic [2:0] async_in;     // Raw outside levels
  logic [2:0] in_rise;      // Agreed rising edges
  assign async_in = {vs_in_i, hs_in_i, pclk_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic s1, s2, s3, lvl;  // Stage one feeds stage two only
      // Three stages; a change counts once stages two and three agree
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1  <= 1'b0;
          s2  <= 1'b0;
          s3  <= 1'b0;
          lvl <= 1'b0;
        end else begin
          s1 <= async_in[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            lvl <= s3;
          end
        end
      end
      assign in_rise[gi] = (s2 == s3) && s3 && !lvl;
    end
  endgenerate

  logic tick;  // One pixel clock has passed
  assign tick = in_rise[0];

  // ========================================================
  // Register file over classic Wishbone
  // ========================================================
  lvt_pkg::lvt_cfg_s cfg;     // Programmed settings
  logic [5:0] idx;            // Word index of access
  logic       wb_req;         // New request seen
  logic       wb_wr;          // Write takes effect now
  assign idx    = wb_adr_i[7:2];
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

  // Writes land on the edge where the master sees ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= '0;
    end else if (wb_wr) begin
      if (idx == lvt_pkg::LVT_IDX_LINE_LO) begin
        cfg.line_len[7:0] <= wb_dat_i[7:0];
      end else if (idx == lvt_pkg::LVT_IDX_LINE_HI) begin
        cfg.line_len[11:8] <= wb_dat_i[3:0];
      end else if (idx == lvt_pkg::LVT_IDX_VSIZ_LO) begin
        cfg.vsize[7:0] <= wb_dat_i[7:0];
      end else if (idx == lvt_pkg::LVT_IDX_VSIZ_HI) begin
        cfg.vsize[11:8] <= wb_dat_i[3:0];
      end else if (idx == lvt_pkg::LVT_IDX_SDLY_LO) begin
        cfg.sdly[7:0] <= wb_dat_i[7:0];
      end else if (idx == lvt_pkg::LVT_IDX_SDLY_HI) begin
        cfg.sdly[11:8] <= wb_dat_i[3:0];
      end else if (idx == lvt_pkg::LVT_IDX_HSW_LO) begin
        cfg.hsw[7:0] <= wb_dat_i[7:0];
      end else if (idx == lvt_pkg::LVT_IDX_HSW_HI) begin
        cfg.hsw[9:8] <= wb_dat_i[1:0];
      end else if (idx == lvt_pkg::LVT_IDX_VSW_LO) begin
        cfg.vsw[7:0] <= wb_dat_i[7:0];
      end else if (idx == lvt_pkg::LVT_IDX_VSW_HI) begin
        cfg.vsw[9:8] <= wb_dat_i[1:0];
      end else if (idx == lvt_pkg::LVT_IDX_HBP) begin
        cfg.hbp <= wb_dat_i[7:0];
      end else if (idx == lvt_pkg::LVT_IDX_VBP) begin
        cfg.vbp <= wb_dat_i[7:0];
      end else if (idx == lvt_pkg::LVT_IDX_HFP) begin
        cfg.hfp <= wb_dat_i[7:0];
      end else if (idx == lvt_pkg::LVT_IDX_VFP) begin
        cfg.vfp <= wb_dat_i[7:0];
      end else if (idx == lvt_pkg::LVT_IDX_PGEN) begin
        cfg.tp_en <= wb_dat_i[lvt_pkg::LVT_TP_BIT];
      end
    end
  end

  // Read mux; unused high bits and unmapped words read zero
  logic [31:0] next_rdata;  // Word for the answer
  logic [7:0]  stat;        // Live block state
  always_comb begin
    next_rdata = '0;
    if (idx == lvt_pkg::LVT_IDX_LINE_LO) begin
      next_rdata[7:0] = cfg.line_len[7:0];
    end else if (idx == lvt_pkg::LVT_IDX_LINE_HI) begin
      next_rdata[3:0] = cfg.line_len[11:8];
    end else if (idx == lvt_pkg::LVT_IDX_VSIZ_LO) begin
      next_rdata[7:0] = cfg.vsize[7:0];
    end else if (idx == lvt_pkg::LVT_IDX_VSIZ_HI) begin
      next_rdata[3:0] = cfg.vsize[11:8];
    end else if (idx == lvt_pkg::LVT_IDX_SDLY_LO) begin
      next_rdata[7:0] = cfg.sdly[7:0];
    end else if (idx == lvt_pkg::LVT_IDX_SDLY_HI) begin
      next_rdata[3:0] = cfg.sdly[11:8];
    end else if (idx == lvt_pkg::LVT_IDX_HSW_LO) begin
      next_rdata[7:0] = cfg.hsw[7:0];
    end else if (idx == lvt_pkg::LVT_IDX_HSW_HI) begin
      next_rdata[1:0] = cfg.hsw[9:8];
    end else if (idx == lvt_pkg::LVT_IDX_VSW_LO) begin
      next_rdata[7:0] = cfg.vsw[7:0];
    end else if (idx == lvt_pkg::LVT_IDX_VSW_HI) begin
      next_rdata[1:0] = cfg.vsw[9:8];
    end else if (idx == lvt_pkg::LVT_IDX_HBP) begin
      next_rdata[7:0] = cfg.hbp;
    end else if (idx == lvt_pkg::LVT_IDX_VBP) begin
      next_rdata[7:0] = cfg.vbp;
    end else if (idx == lvt_pkg::LVT_IDX_HFP) begin
      next_rdata[7:0] = cfg.hfp;
    end else if (idx == lvt_pkg::LVT_IDX_VFP) begin
      next_rdata[7:0] = cfg.vfp;
    end else if (idx == lvt_pkg::LVT_IDX_PGEN) begin
      next_rdata[lvt_pkg::LVT_TP_BIT] = cfg.tp_en;
    end else if (idx == lvt_pkg::LVT_IDX_STAT) begin
      next_rdata[7:0] = stat;
    end
  end

  // Answer one cycle after the request, then drop ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // ========================================================
  // Sync forwarding delay, one counter per sync kind
  // ========================================================
  logic [1:0] fire;  // Delayed sync due now: 0 line, 1 frame
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dly
      logic [12:0] cnt;   // Pixel clocks still to wait
      logic        busy;  // A sync is in flight
      // A new sync restarts the wait; the host keeps delay >= 32
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt  <= '0;
          busy <= 1'b0;
        end else if (in_rise[gi + 1]) begin
          cnt  <= 13'(cfg.sdly) + lvt_pkg::LVT_PIPE_PIX;
          busy <= 1'b1;
        end else if (busy && tick) begin
          cnt <= cnt - lvt_pkg::LVT_ONE;
          if (cnt <= lvt_pkg::LVT_ONE) begin
            busy <= 1'b0;
          end
        end
      end
      assign fire[gi] = busy && tick && (cnt <= lvt_pkg::LVT_ONE) && !in_rise[gi + 1];
    end
  endgenerate

  // ========================================================
  // Horizontal phase machine
  // ========================================================
  lvt_pkg::lvt_h_e h_st;      // Current line phase
  logic [12:0]     h_cnt;     // Pixel clocks left in phase
  logic [11:0]     h_pos;     // Pixel number in active part
  logic            line_go;   // A new hsync starts now
  logic            tp;        // Pattern running
  assign tp = cfg.tp_en;

  // Normal mode waits for a delayed sync; pattern mode loops
  assign line_go = tp ? (tick && (h_st == lvt_pkg::H_IDLE ||
                   (h_st == lvt_pkg::H_FP && h_cnt <= lvt_pkg::LVT_ONE)))
                 : fire[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      h_st  <= lvt_pkg::H_IDLE;
      h_cnt <= '0;
      h_pos <= '0;
    end else if (line_go) begin
      h_st  <= lvt_pkg::H_SYNC;
      h_cnt <= 13'(cfg.hsw);
      h_pos <= '0;
    end else if (!tp && h_st == lvt_pkg::H_FP) begin
      // Pattern switched off mid porch: leave at once
      h_st <= lvt_pkg::H_IDLE;
    end else if (tick) begin
      h_cnt <= h_cnt - lvt_pkg::LVT_ONE;
      case (h_st)
        lvt_pkg::H_SYNC: begin
          if (h_cnt <= lvt_pkg::LVT_ONE) begin
            h_st  <= lvt_pkg::H_BP;
            h_cnt <= 13'(cfg.hbp);
          end
        end
        lvt_pkg::H_BP: begin
          if (h_cnt <= lvt_pkg::LVT_ONE) begin
            h_st  <= lvt_pkg::H_ACT;
            h_cnt <= 13'(cfg.line_len);
            h_pos <= 12'h001;  // Pixel zero goes out on this tick
          end
        end
        lvt_pkg::H_ACT: begin
          h_pos <= h_pos + 12'h001;
          if (h_cnt <= lvt_pkg::LVT_ONE) begin
            // Front porch only exists for the pattern
            h_st  <= tp ? lvt_pkg::H_FP : lvt_pkg::H_IDLE;
            h_cnt <= 13'(cfg.hfp);
          end
        end
        lvt_pkg::H_FP: begin
          if (!tp) begin
            h_st <= lvt_pkg::H_IDLE;
          end
        end
        default: begin
          h_cnt <= '0;
        end
      endcase
    end
  end

  // ========================================================
  // Vertical: pattern phases and forwarded vsync length
  // ========================================================
  lvt_pkg::lvt_v_e v_st;    // Pattern frame phase
  logic [12:0]     v_cnt;   // Lines left in phase
  logic [11:0]     v_pos;   // Active line number
  logic            nvs_on;  // Forwarded vsync active
  logic [12:0]     nvs_cnt; // Lines left of forwarded vsync

  // Pattern frame advances one line per hsync start
  always_ff @(posedge clk_i) begin
    if (rst_i || !tp) begin
      v_st  <= lvt_pkg::V_SYNC;
      v_cnt <= 13'(cfg.vsw);
      v_pos <= '0;
    end else if (line_go) begin
      v_cnt <= v_cnt - lvt_pkg::LVT_ONE;
      if (v_st == lvt_pkg::V_ACT) begin
        v_pos <= v_pos + 12'h001;
      end
      if (v_cnt <= lvt_pkg::LVT_ONE) begin
        case (v_st)
          lvt_pkg::V_SYNC: begin
            v_st  <= lvt_pkg::V_BP;
            v_cnt <= 13'(cfg.vbp);
          end
          lvt_pkg::V_BP: begin
            v_st  <= lvt_pkg::V_ACT;
            v_cnt <= 13'(cfg.vsize);
            v_pos <= '0;
          end
          lvt_pkg::V_ACT: begin
            v_st  <= lvt_pkg::V_FP;
            v_cnt <= 13'(cfg.vfp);
          end
          default: begin
            v_st  <= lvt_pkg::V_SYNC;
            v_cnt <= 13'(cfg.vsw);
          end
        endcase
      end
    end
  end

  // Forwarded vsync lasts the programmed number of lines
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nvs_on  <= 1'b0;
      nvs_cnt <= '0;
    end else if (fire[1] && !tp) begin
      nvs_on  <= 1'b1;
      nvs_cnt <= 13'(cfg.vsw);
    end else if (nvs_on && line_go) begin
      nvs_cnt <= nvs_cnt - lvt_pkg::LVT_ONE;
      if (nvs_cnt <= lvt_pkg::LVT_ONE) begin
        nvs_on <= 1'b0;
      end
    end
  end

  // ========================================================
  // Two-entry pixel buffer
  // ========================================================
  lvt_pkg::lvt_pix_t buf_mem [2];  // Storage
  logic       wr_ptr, rd_ptr;      // Entry pointers
  logic [1:0] buf_cnt;             // Words held
  logic       push, pop;           // Fill and drain
  logic       pix_due;             // Active pixel slot now
  logic [1:0] next_cnt;            // Fill after this cycle
  // Slots start on the tick that opens active, so each pixel meets its de slot
  assign pix_due  = tick && !line_go && (h_st == lvt_pkg::H_ACT ? h_cnt > lvt_pkg::LVT_ONE
                    : h_st == lvt_pkg::H_BP && h_cnt <= lvt_pkg::LVT_ONE);
  assign push     = in_valid_i && in_ready_o;
  // The panel pace drains it; pattern mode never pops it
  assign pop      = pix_due && !tp && buf_cnt != 2'h0;
  assign next_cnt = buf_cnt + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      buf_cnt    <= '0;
      in_ready_o <= 1'b0;
    end else begin
      if (push) begin
        buf_mem[wr_ptr] <= in_data_i;
        wr_ptr          <= !wr_ptr;
      end
      if (pop) begin
        rd_ptr <= !rd_ptr;
      end
      buf_cnt    <= next_cnt;
      in_ready_o <= next_cnt != lvt_pkg::LVT_BUF_DEPTH;
    end
  end

  // ========================================================
  // Panel outputs, all registered
  // ========================================================
  lvt_pkg::lvt_pix_t next_pix;  // Pixel for this slot
  always_comb begin
    next_pix = '0;
    if (tp) begin
      // Generated ramp and grid
      next_pix = {h_pos[7:0], v_pos[7:0], h_pos[7:0] ^ v_pos[7:0]};
    end else if (pop) begin
      next_pix = buf_mem[rd_ptr];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hsync_o     <= 1'b0;
      vsync_o     <= 1'b0;
      de_o        <= 1'b0;
      ch_a_data_o <= '0;
      ch_b_data_o <= '0;
      ch_b_en_o   <= 1'b0;
    end else begin
      hsync_o   <= h_st == lvt_pkg::H_SYNC;
      vsync_o   <= tp ? v_st == lvt_pkg::V_SYNC : nvs_on;
      de_o      <= h_st == lvt_pkg::H_ACT && (!tp || v_st == lvt_pkg::V_ACT);
      ch_b_en_o <= !chan_single_i;
      if (pix_due) begin
        ch_a_data_o <= next_pix;
        ch_b_data_o <= chan_single_i ? '0 : next_pix;
      end else if (chan_single_i) begin
        ch_b_data_o <= '0;
      end
    end
  end

  assign stat = {3'h0, tp, buf_cnt, nvs_on || v_st == lvt_pkg::V_SYNC && tp,
                 h_st == lvt_pkg::H_ACT};

  // ========================================================
  // Checks
  // ========================================================
  logic [12:0] ph_ticks;  // Ticks since phase entry
  always_ff @(posedge clk_i) begin
    if (rst_i || line_go || tick && h_cnt <= lvt_pkg::LVT_ONE) begin
      ph_ticks <= '0;
    end else if (tick) begin
      ph_ticks <= ph_ticks + lvt_pkg::LVT_ONE;
    end
  end

  function automatic logic [12:0] atl1(input logic [12:0] v);
    return (v == '0) ? lvt_pkg::LVT_ONE : v;
  endfunction

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_ends(lvt_pkg::lvt_h_e st);
    $past(h_st) == st && h_st != st && !$past(line_go);
  endsequence

  a_wb_answer: assert property (s_req |=> s_ans)
    else $error("wishbone answer not one cycle");
  a_hsync_width: assert property (s_ends(lvt_pkg::H_SYNC) |->
    $past(ph_ticks) + lvt_pkg::LVT_ONE == atl1(13'(cfg.hsw)))
    else $error("hsync width wrong");
  a_back_porch_len: assert property (s_ends(lvt_pkg::H_BP) |->
    $past(ph_ticks) + lvt_pkg::LVT_ONE == atl1(13'(cfg.hbp)))
    else $error("back porch wrong");
  a_active_line_len: assert property (s_ends(lvt_pkg::H_ACT) |->
    $past(ph_ticks) + lvt_pkg::LVT_ONE == atl1(13'(cfg.line_len)))
    else $error("active line length wrong");
  a_front_porch_len: assert property ($past(h_st) == lvt_pkg::H_FP
    && $past(line_go) && tp |->
    $past(ph_ticks) + lvt_pkg::LVT_ONE == atl1(13'(cfg.hfp)))
    else $error("front porch wrong");
  a_sync_delay_load: assert property (in_rise[1] |=>
    g_dly[0].cnt == 13'(cfg.sdly) + lvt_pkg::LVT_PIPE_PIX)
    else $error("sync delay load wrong");
  a_fp_pattern_only: assert property (!tp |-> ##1 h_st != lvt_pkg::H_FP || tp)
    else $error("front porch outside pattern");
  a_tp_vsync_out: assert property (tp && v_st == lvt_pkg::V_SYNC ##1 tp |-> vsync_o)
    else $error("pattern vsync missing");
  a_chan_b_single: assert property ($past(chan_single_i) |->
    !ch_b_en_o && ch_b_data_o == '0)
    else $error("channel B driven in single mode");
  a_buf_ready_honest: assert property (!$past(rst_i) |->
    in_ready_o == (buf_cnt != lvt_pkg::LVT_BUF_DEPTH))
    else $error("buffer ready disagrees with fill");

endmodule
`default_nettype wire

// file: lvt_pkg.sv
// ==========================================================
// Constants and types of the video timing block
// ==========================================================
package lvt_pkg;

  // ========================================================
  // Register indices, byte address is four times the index
  // ========================================================
  localparam logic [5:0] LVT_IDX_LINE_LO = 6'h20; // Line pixels low
  localparam logic [5:0] LVT_IDX_LINE_HI = 6'h21; // Line pixels high
  localparam logic [5:0] LVT_IDX_VSIZ_LO = 6'h24; // Frame lines low
  localparam logic [5:0] LVT_IDX_VSIZ_HI = 6'h25; // Frame lines high
  localparam logic [5:0] LVT_IDX_SDLY_LO = 6'h28; // Sync delay low
  localparam logic [5:0] LVT_IDX_SDLY_HI = 6'h29; // Sync delay high
  localparam logic [5:0] LVT_IDX_HSW_LO  = 6'h2C; // Hsync width low
  localparam logic [5:0] LVT_IDX_HSW_HI  = 6'h2D; // Hsync width high
  localparam logic [5:0] LVT_IDX_VSW_LO  = 6'h30; // Vsync width low
  localparam logic [5:0] LVT_IDX_VSW_HI  = 6'h31; // Vsync width high
  localparam logic [5:0] LVT_IDX_HBP     = 6'h34; // H back porch
  localparam logic [5:0] LVT_IDX_VBP     = 6'h36; // V back porch
  localparam logic [5:0] LVT_IDX_HFP     = 6'h38; // H front porch
  localparam logic [5:0] LVT_IDX_VFP     = 6'h3A; // V front porch
  localparam logic [5:0] LVT_IDX_PGEN    = 6'h3C; // Pattern control
  localparam logic [5:0] LVT_IDX_STAT    = 6'h3E; // Status, read only

  // ========================================================
  // Field layout
  // ========================================================
  localparam int LVT_TP_BIT   = 4;  // Pattern enable bit
  localparam int LVT_ST_HACT  = 0;  // Status: line active
  localparam int LVT_ST_VSYNC = 1;  // Status: vsync out
  localparam int LVT_ST_BUF0  = 2;  // Status: buffer fill, 2 bits
  localparam int LVT_ST_TP    = 4;  // Status: pattern running

  // ========================================================
  // Timing figures in pixel clocks, and the buffer depth
  // ========================================================
  localparam logic [12:0] LVT_PIPE_PIX = 13'h00A; // Extra sync latency
  localparam logic [11:0] LVT_SDLY_MIN = 12'h020; // Least legal delay
  localparam logic [12:0] LVT_ONE      = 13'h001; // Shortest phase
  localparam logic [1:0]  LVT_BUF_DEPTH = 2'h2;   // Buffer entries

  typedef logic [23:0] lvt_pix_t;  // One RGB pixel

  // Timing settings as software sees them
  typedef struct packed {
    logic [11:0] line_len;
    logic [11:0] vsize;
    logic [11:0] sdly;
    logic [9:0]  hsw;
    logic [9:0]  vsw;
    logic [7:0]  hbp;
    logic [7:0]  vbp;
    logic [7:0]  hfp;
    logic [7:0]  vfp;
    logic        tp_en;
  } lvt_cfg_s;

  typedef enum logic [2:0] {H_IDLE, H_SYNC, H_BP, H_ACT, H_FP} lvt_h_e;
  typedef enum logic [1:0] {V_SYNC, V_BP, V_ACT, V_FP} lvt_v_e;

endpackage

// file: lvt_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Panel model: logs edge times and counts
// ==========================================
module lvt_panel_model (
  input  wire logic              clk_i, // System clock
  input  wire logic              rst_i, // Reset, active high
  input  wire logic              hs_i,  // Panel hsync
  input  wire logic              vs_i,  // Panel vsync
  input  wire logic              de_i,  // Data enable
  input  wire lvt_pkg::lvt_pix_t a_i,   // Channel A pixel
  input  wire lvt_pkg::lvt_pix_t b_i,   // Channel B pixel
  output logic [31:0]            t_o [7], // Stamps: now,hr,hf,dr,df,hfp,vr
  output logic [31:0]            n_o [3], // Hs rises, de falls, vs rises
  output lvt_pkg::lvt_pix_t      pa_o [3], // First A pixels
  output lvt_pkg::lvt_pix_t      pb_o [3]  // First B pixels
);
  logic        hq, vq, dq, fl; // Last levels, porch open
  logic [15:0] cd;             // Cycles into active
  // Listens only: a panel never stalls the link
  always @(posedge clk_i) begin
    hq <= hs_i;
    vq <= vs_i;
    dq <= de_i;
    cd <= de_i ? cd + 16'h1 : 16'h0;
    t_o[0] <= rst_i ? 32'h0 : t_o[0] + 32'h1;
    if (rst_i) begin
      n_o <= '{32'h0, 32'h0, 32'h0};
      fl <= 1'h0;
    end
    // Front porch is only timed from a de fall
    if (hs_i && !hq) begin
      t_o[1] <= t_o[0];
      n_o[0] <= n_o[0] + 32'h1;
      fl <= 1'h0;
      if (fl) begin
        t_o[5] <= t_o[0] - t_o[4];
      end
    end
    if (!hs_i && hq) begin
      t_o[2] <= t_o[0];
    end
    if (de_i && !dq) begin
      t_o[3] <= t_o[0];
    end
    if (!de_i && dq) begin
      t_o[4] <= t_o[0];
      n_o[1] <= n_o[1] + 32'h1;
      fl <= 1'h1;
    end
    if (vs_i && !vq) begin
      t_o[6] <= t_o[0];
      n_o[2] <= n_o[2] + 32'h1;
    end
    // Mid-tick samples of the first three pixels
    if (de_i && cd[2:0] == 3'h4 && cd < 16'h18) begin
      pa_o[cd[4:3]] <= a_i;
      pb_o[cd[4:3]] <= b_i;
    end
  end
endmodule
`default_nettype wire

// file: lvt_video_timing_test.sv
`timescale 1ns/1ps
`default_nettype none
module lvt_video_timing_test;
  // ==========================================
  // Signals
  // ==========================================
  logic        clk = 1'h0, rst = 1'h1, pclk = 1'h0; // Clocks, reset
  logic        cyc = 1'h0, we = 1'h0, hs = 1'h0;    // Bus, line sync
  logic        vs = 1'h0, sgl = 1'h0, vld = 1'h0;   // Frame sync, mode
  logic [7:0]  adr = 8'h00;                         // Byte address
  logic [3:0]  sel = 4'hF;                          // Byte lanes
  logic [31:0] wd = 32'h0, rd, rdat;                // Bus data
  lvt_pkg::lvt_pix_t din = 24'h0, cha, chb;         // Pixels
  logic        ack, rdy, hso, vso, deo, ben;        // Outputs
  logic [31:0] t [7], n [3];                        // Panel log
  lvt_pkg::lvt_pix_t pa [3], pb [3], ex [3];        // Captured pixels
  logic [5:0]  ri [14] = '{6'h20, 6'h21, 6'h24, 6'h25, 6'h28, 6'h29,
                           6'h2C, 6'h2D, 6'h30, 6'h31, 6'h34, 6'h36, 6'h38, 6'h3A};
  int          err_count = 0, num_checks = 0;
  // Pixel clock is free running, phase unrelated to clk
  initial forever #25 clk = ~clk;
  initial begin
    #37;
    forever #200 pclk = ~pclk;
  end
  lvt_video_timing dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
    .wb_ack_o(ack), .pclk_i(pclk), .hs_in_i(hs), .vs_in_i(vs), .chan_single_i(sgl),
    .in_valid_i(vld), .in_data_i(din), .in_ready_o(rdy), .hsync_o(hso), .vsync_o(vso),
    .de_o(deo), .ch_a_data_o(cha), .ch_b_data_o(chb), .ch_b_en_o(ben));
  lvt_panel_model panel (.clk_i(clk), .rst_i(rst), .hs_i(hso), .vs_i(vso), .de_i(deo),
    .a_i(cha), .b_i(chb), .t_o(t), .n_o(n), .pa_o(pa), .pb_o(pb));
  // ==========================================
  // Helpers
  // ==========================================
  function automatic logic [7:0] msk(input logic [5:0] i); // Implemented bits
    return (i == 6'h21 || i == 6'h25 || i == 6'h29) ? 8'h0F :
           (i == 6'h2D || i == 6'h31) ? 8'h03 : 8'hFF;
  endfunction
  function automatic logic [31:0] tk(input logic [11:0] c); // Eight cycles a tick
    return {17'h0, c, 3'h0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  // Classic cycle: hold until ack, release at that edge
  task automatic bus(input logic [5:0] i, input logic w, input logic [7:0] d);
    cyc <= 1'h1;
    we <= w;
    adr <= {i, 2'h0};
    wd <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'h1);
    rdat = rd;
    cyc <= 1'h0;
    @(posedge clk);
  endtask
  task automatic w2(input logic [5:0] i, input logic [11:0] v); // Low then high part
    bus(i, 1'h1, v[7:0]);
    bus(i + 6'h1, 1'h1, {4'h0, v[11:8]});
  endtask
  task automatic wt(input int j); // Wait for a panel count to move
    logic [31:0] v;
    v = n[j];
    while (n[j] === v) begin
      @(posedge clk);
    end
  endtask
  task automatic complete_run();
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    complete_run();
  end
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    logic [11:0] sd, hw, bp, ln, fp, vw, vb, vz, vf;
    logic [31:0] t0, h0, d0;
    logic [7:0]  v;
    int          k;
    void'($urandom(15));
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    for (int i = 0; i < 14; i++) begin
      bus(ri[i], 1'h0, 8'h00);
      chk("reset", 32'h0, rdat);
      v = 8'($urandom);
      bus(ri[i], 1'h1, v);
      bus(ri[i], 1'h0, 8'h00);
      chk("readback", {24'h0, v & msk(ri[i])}, rdat);
    end
    bus(6'h22, 1'h1, 8'hFF);
    bus(6'h22, 1'h0, 8'h00);
    chk("unmapped", 32'h0, rdat);
    // Delay kept at 32 or more, as the host must
    sd = 12'h120 + 12'($urandom % 16);
    hw = 12'h101 + 12'($urandom % 4);
    bp = 12'h001 + 12'($urandom % 8);
    ln = 12'h100 + 12'($urandom % 8);
    w2(6'h28, sd);
    w2(6'h2C, hw);
    w2(6'h20, ln);
    w2(6'h30, 12'h001);
    bus(6'h34, 1'h1, bp[7:0]);
    for (int m = 0; m < 2; m++) begin
      sgl <= m[0];
      ex = '{24'($urandom), 24'($urandom), 24'h0};
      k = 0;
      vld <= 1'h1;
      din <= ex[0];
      // Offer words for six cycles; the buffer refuses once full
      repeat (6) begin
        @(posedge clk);
        if (rdy === 1'h1) begin
          k++;
          din <= (k == 1) ? ex[1] : 24'($urandom);
        end
      end
      vld <= 1'h0;
      chk("fill", 32'h2, k);
      t0 = t[0];
      hs <= 1'h1;
      vs <= 1'h1;
      repeat (4) @(posedge clk);
      hs <= 1'h0;
      vs <= 1'h0;
      wt(1);
      d0 = t[1] - t0;
      chk("hs delay", 32'h1, 32'(d0 >= tk(sd + 12'h9) && d0 <= tk(sd + 12'hC)));
      d0 = t[6] - t0;
      if (m == 0) begin
        chk("vs delay", 32'h1, 32'(d0 >= tk(sd + 12'h9) && d0 <= tk(sd + 12'hC)));
      end
      chk("hs width", tk(hw), t[2] - t[1]);
      chk("h back porch", tk(bp), t[3] - t[2]);
      chk("active", tk(ln), t[4] - t[3]);
      for (int j = 0; j < 3; j++) begin
        chk("chan a", ex[j], pa[j]);
        chk("chan b", m ? 24'h0 : ex[j], pb[j]);
      end
      chk("b enable", {31'h0, !m[0]}, ben);
    end
    h0 = n[0];
    repeat (3000) @(posedge clk);
    chk("free run", h0, n[0]);
    ln = 12'h003 + 12'($urandom % 3);
    hw = 12'h001 + 12'($urandom % 3);
    fp = 12'h001 + 12'($urandom % 3);
    vw = 12'h001 + 12'($urandom % 3);
    vb = 12'h001 + 12'($urandom % 3);
    vz = 12'h002 + 12'($urandom % 3);
    vf = 12'h001 + 12'($urandom % 3);
    w2(6'h20, ln);
    w2(6'h2C, hw);
    w2(6'h30, vw);
    w2(6'h24, vz);
    bus(6'h38, 1'h1, fp[7:0]);
    bus(6'h36, 1'h1, vb[7:0]);
    bus(6'h3A, 1'h1, vf[7:0]);
    bus(6'h3C, 1'h1, 8'h10);
    bus(6'h3C, 1'h0, 8'h00);
    chk("pattern ctrl", 32'h10, rdat);
    wt(2);
    wt(2);
    h0 = n[0];
    t0 = n[1];
    wt(2);
    chk("frame lines", {20'h0, vw + vb + vz + vf}, n[0] - h0);
    chk("active lines", {20'h0, vz}, n[1] - t0);
    wt(1);
    chk("pat hs width", tk(hw), t[2] - t[1]);
    chk("pat back porch", tk(bp), t[3] - t[2]);
    chk("pat active", tk(ln), t[4] - t[3]);
    chk("front porch", tk(fp), t[5]);
    complete_run();
  end
endmodule
`default_nettype wire
